// ---- hdl/pc_stack_pkg.sv ----
package pc_stack_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int DEPTH = 31;
    localparam logic [4:0] SP_MAX = 5'h1F;
    localparam logic [4:0] SP_ZERO = 5'h00;
    localparam logic [20:0] PC_STEP = 21'h00_0002;
    localparam logic [20:0] RESET_VECTOR = 21'h00_0000;
    localparam logic [20:0] HIGH_VECTOR = 21'h00_0008;
    localparam logic [20:0] LOW_VECTOR = 21'h00_0018;
    localparam logic [20:0] MEM_8K = 21'h00_2000;
    localparam logic [20:0] MEM_16K = 21'h00_4000;
    // Register byte addresses on the AXI4-Lite slave; ADDR_COUNTER_FULL is not decoded and answers SLVERR
    localparam logic [7:0] ADDR_COUNTER_LOW = 8'h00;
    localparam logic [7:0] ADDR_HIGH_LATCH = 8'h04;
    localparam logic [7:0] ADDR_UPPER_LATCH = 8'h08;
    localparam logic [7:0] ADDR_STACK_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_TOP_LOW = 8'h10;
    localparam logic [7:0] ADDR_TOP_HIGH = 8'h14;
    localparam logic [7:0] ADDR_TOP_UPPER = 8'h18;
    localparam logic [7:0] ADDR_CONFIG = 8'h1C;
    localparam logic [7:0] ADDR_COUNTER_FULL = 8'h20;
    // Stack status and config fields, bus responses
    localparam int FULL_BIT = 7;
    localparam int UNDER_BIT = 6;
    localparam int CFG_OVR_BIT = 0;
    localparam logic CFG_OVR_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Decoder commands
    typedef enum logic [3:0] {
        CMD_NONE, CMD_SEQ, CMD_JUMP, CMD_CALL, CMD_RETURN, CMD_INT_HIGH,
        CMD_INT_LOW, CMD_SW_PUSH, CMD_SW_POP
    } cmd_t;
endpackage : pc_stack_pkg

// ---- hdl/program_counter_return_stack.sv ----
// Functional notes
// - Program counter is 21 bits wide, covering a 2 Mbyte space.
// - Fetches above implemented memory return all zeros, a no-operation.
// - Reset starts at 0000h; interrupts enter at 0008h or 0018h.
// - Implemented memory is 8 or 16 Kbytes, a build parameter.
// - Low byte directly accessible; upper bytes only through two latches.
// - Writing the low byte loads the upper bytes from the latches.
// - Reading the low byte copies the upper bytes into the latches.
// - Bit zero is always zero; sequential instructions advance by two.
// - Calls, gotos and branches load the target directly, latches unused.
// - 31 by 21-bit stack, 5-bit pointer; push on call/interrupt, pop on return.
// - Push increments then writes; pop reads then decrements.
// - Every reset clears the pointer; entry zero has no storage.
// - Top entry and pointer are software readable and writable.
// - With option set, 31st push stores PC+2, sets full, resets device.
// - With option clear, full at 31, later pushes ignored.
// - Empty pop loads zero, sets underflow; resets device if option set.
// - Full and underflow cleared only by software write or power-on.
// - Status holds full bit 7, underflow bit 6, zero bit 5, pointer 4:0.
// - Software push stores current counter; software pop discards the top.
// - Shadow store saves status, working, bank on interrupt or fast call.
// - Every interrupt overwrites the shadow store, even nested.
`timescale 1ns/100ps
module program_counter_return_stack #(
    parameter bit BIG_MEMORY = 1'b0
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic por_n,
    // Decoder and interrupt controller
    input wire pc_stack_pkg::cmd_t cmd,
    input wire logic [20:0] target,
    input wire logic fast,
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] bank_select_register_in,
    // Program address and fetch data
    output logic [20:0] fetch_addr,
    input wire logic [15:0] mem_rdata,
    output logic [15:0] fetch_data,
    // Fast restore and stack reset request
    output logic restore_valid,
    output logic [7:0] status_out,
    output logic [7:0] working_register_out,
    output logic [7:0] bank_select_register_out,
    output logic stack_reset_req,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    localparam logic [20:0] MEM_TOP = BIG_MEMORY ? pc_stack_pkg::MEM_16K : pc_stack_pkg::MEM_8K;

    logic [20:0] pc_q;
    logic [7:0] high_latch_q;
    logic [4:0] upper_latch_q;
    logic [4:0] sp_q;
    logic full_q;
    logic under_q;
    logic ovr_reset_q;
    logic [20:0] stack_mem [1:31];
    logic [7:0] shadow_status_q, shadow_work_q, shadow_bank_q;

    function automatic logic [20:0] align(input logic [20:0] a);
        return {a[20:1], 1'b0};
    endfunction : align

    // Register write channel
    logic [7:0] aw_addr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    assign wr_go = aw_have_q && w_have_q && !s_bvalid;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= pc_stack_pkg::RESP_OKAY;
        end else begin
            s_awready <= !aw_have_q && !(s_awvalid && s_awready);
            s_wready <= !w_have_q && !(s_wvalid && s_wready);
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (aw_addr_q > pc_stack_pkg::ADDR_CONFIG || aw_addr_q[1:0] != 2'b00)
                    ? pc_stack_pkg::RESP_SLVERR : pc_stack_pkg::RESP_OKAY;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    logic sw_we;
    assign sw_we = wr_go && w_strb_q[0];
    logic wr_pcl, wr_hl, wr_ul, wr_stat, wr_tl, wr_th, wr_tu, wr_cfg;
    assign wr_pcl = sw_we && aw_addr_q == pc_stack_pkg::ADDR_COUNTER_LOW;
    assign wr_hl = sw_we && aw_addr_q == pc_stack_pkg::ADDR_HIGH_LATCH;
    assign wr_ul = sw_we && aw_addr_q == pc_stack_pkg::ADDR_UPPER_LATCH;
    assign wr_stat = sw_we && aw_addr_q == pc_stack_pkg::ADDR_STACK_STATUS;
    assign wr_tl = sw_we && aw_addr_q == pc_stack_pkg::ADDR_TOP_LOW;
    assign wr_th = sw_we && aw_addr_q == pc_stack_pkg::ADDR_TOP_HIGH;
    assign wr_tu = sw_we && aw_addr_q == pc_stack_pkg::ADDR_TOP_UPPER;
    assign wr_cfg = sw_we && aw_addr_q == pc_stack_pkg::ADDR_CONFIG;

    // Read channel
    logic rd_go, rd_pcl;
    assign rd_go = s_arvalid && s_arready;
    assign rd_pcl = rd_go && s_araddr == pc_stack_pkg::ADDR_COUNTER_LOW;
    logic [20:0] top_val;
    assign top_val = (sp_q == pc_stack_pkg::SP_ZERO) ? 21'h00_0000 : stack_mem[sp_q];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= pc_stack_pkg::RESP_OKAY;
        end else begin
            s_arready <= !s_rvalid && !rd_go;
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rresp <= pc_stack_pkg::RESP_OKAY;
                case (s_araddr)
                    pc_stack_pkg::ADDR_COUNTER_LOW: s_rdata <= {24'h00_0000, pc_q[7:0]};
                    pc_stack_pkg::ADDR_HIGH_LATCH: s_rdata <= {24'h00_0000, high_latch_q};
                    pc_stack_pkg::ADDR_UPPER_LATCH: s_rdata <= {27'h000_0000, upper_latch_q};
                    pc_stack_pkg::ADDR_STACK_STATUS: s_rdata <= {24'h00_0000, full_q, under_q, 1'b0, sp_q};
                    pc_stack_pkg::ADDR_TOP_LOW: s_rdata <= {24'h00_0000, top_val[7:0]};
                    pc_stack_pkg::ADDR_TOP_HIGH: s_rdata <= {24'h00_0000, top_val[15:8]};
                    pc_stack_pkg::ADDR_TOP_UPPER: s_rdata <= {27'h000_0000, top_val[20:16]};
                    pc_stack_pkg::ADDR_CONFIG: s_rdata <= {31'h0000_0000, ovr_reset_q};
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= pc_stack_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Stack events
    logic is_push, is_pop, is_int, overflow_ev, under_ev, stack_rst;
    assign is_int = cmd == pc_stack_pkg::CMD_INT_HIGH || cmd == pc_stack_pkg::CMD_INT_LOW;
    assign is_push = cmd == pc_stack_pkg::CMD_CALL || is_int || cmd == pc_stack_pkg::CMD_SW_PUSH;
    assign is_pop = cmd == pc_stack_pkg::CMD_RETURN || cmd == pc_stack_pkg::CMD_SW_POP;
    assign overflow_ev = is_push && sp_q >= 5'(pc_stack_pkg::DEPTH - 1);
    assign under_ev = is_pop && sp_q == pc_stack_pkg::SP_ZERO;
    assign stack_rst = ovr_reset_q && (overflow_ev || under_ev);

    // Configuration option, power-on default set
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            ovr_reset_q <= pc_stack_pkg::CFG_OVR_RESET;
        end else if (wr_cfg) begin
            ovr_reset_q <= w_data_q[pc_stack_pkg::CFG_OVR_BIT];
        end
    end

    // flags survive all but power-on; set wins over clear
    always_ff @(posedge sys_clk or negedge por_n) begin
        if (!por_n) begin
            full_q <= 1'b0;
            under_q <= 1'b0;
        end else begin
            if (overflow_ev) begin
                full_q <= 1'b1;
            end else if (wr_stat && !w_data_q[pc_stack_pkg::FULL_BIT]) begin
                full_q <= 1'b0;
            end
            if (under_ev) begin
                under_q <= 1'b1;
            end else if (wr_stat && !w_data_q[pc_stack_pkg::UNDER_BIT]) begin
                under_q <= 1'b0;
            end
        end
    end

    // pointer cleared by every reset, pointer moves
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sp_q <= pc_stack_pkg::SP_ZERO;
        end else if (stack_rst) begin
            sp_q <= pc_stack_pkg::SP_ZERO;
        end else if (is_push) begin
            if (sp_q != pc_stack_pkg::SP_MAX) begin
                sp_q <= sp_q + 5'h01;
            end
        end else if (is_pop) begin
            if (sp_q != pc_stack_pkg::SP_ZERO) begin
                sp_q <= sp_q - 5'h01;
            end
        end else if (wr_stat) begin
            sp_q <= w_data_q[4:0];
        end
    end

    logic [20:0] push_val;
    assign push_val = (cmd == pc_stack_pkg::CMD_SW_PUSH) ? pc_q : align(pc_q + pc_stack_pkg::PC_STEP);
    always_ff @(posedge sys_clk) begin
        if (is_push && sp_q != pc_stack_pkg::SP_MAX) begin
            stack_mem[sp_q + 5'h01] <= push_val;
        end else if (!is_pop && sp_q != pc_stack_pkg::SP_ZERO) begin
            if (wr_tl) stack_mem[sp_q][7:0] <= w_data_q[7:0];
            if (wr_th) stack_mem[sp_q][15:8] <= w_data_q[7:0];
            if (wr_tu) stack_mem[sp_q][20:16] <= w_data_q[4:0];
        end
    end

    // holding latches, untouched by calls and returns
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            high_latch_q <= 8'h00;
            upper_latch_q <= 5'h00;
        end else if (rd_pcl) begin
            high_latch_q <= pc_q[15:8];
            upper_latch_q <= pc_q[20:16];
        end else begin
            if (wr_hl) high_latch_q <= w_data_q[7:0];
            if (wr_ul) upper_latch_q <= w_data_q[4:0];
        end
    end

    // Program counter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= pc_stack_pkg::RESET_VECTOR;
        end else if (stack_rst) begin
            pc_q <= pc_stack_pkg::RESET_VECTOR;
        end else begin
            case (cmd)
                pc_stack_pkg::CMD_SEQ: pc_q <= align(pc_q + pc_stack_pkg::PC_STEP);
                pc_stack_pkg::CMD_JUMP, pc_stack_pkg::CMD_CALL: pc_q <= align(target);
                pc_stack_pkg::CMD_INT_HIGH: pc_q <= pc_stack_pkg::HIGH_VECTOR;
                pc_stack_pkg::CMD_INT_LOW: pc_q <= pc_stack_pkg::LOW_VECTOR;
                pc_stack_pkg::CMD_RETURN: pc_q <= under_ev ? 21'h00_0000 : align(stack_mem[sp_q]);
                pc_stack_pkg::CMD_SW_PUSH, pc_stack_pkg::CMD_SW_POP: pc_q <= align(pc_q + pc_stack_pkg::PC_STEP);
                default: begin
                    // low byte write loads upper bytes
                    if (wr_pcl) begin
                        pc_q <= {upper_latch_q, high_latch_q, w_data_q[7:1], 1'b0};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            shadow_status_q <= 8'h00;
            shadow_work_q <= 8'h00;
            shadow_bank_q <= 8'h00;
        end else if (is_int || (cmd == pc_stack_pkg::CMD_CALL && fast)) begin
            shadow_status_q <= status_in;
            shadow_work_q <= working_register_in;
            shadow_bank_q <= bank_select_register_in;
        end
    end

    // Outputs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            restore_valid <= 1'b0;
            status_out <= 8'h00;
            working_register_out <= 8'h00;
            bank_select_register_out <= 8'h00;
            stack_reset_req <= 1'b0;
            fetch_data <= 16'h0000;
        end else begin
            restore_valid <= cmd == pc_stack_pkg::CMD_RETURN && fast;
            status_out <= shadow_status_q;
            working_register_out <= shadow_work_q;
            bank_select_register_out <= shadow_bank_q;
            stack_reset_req <= stack_rst;
            fetch_data <= (pc_q >= MEM_TOP) ? 16'h0000 : mem_rdata;
        end
    end
    assign fetch_addr = pc_q;

    // Assertions
    // alignment
    a_pc_even_align: assert property (@(posedge sys_clk) disable iff (!resetn)
        pc_q[0] == 1'b0)
        else $error("counter bit zero set");
    a_seq_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        (cmd == pc_stack_pkg::CMD_SEQ && !stack_rst) |=> pc_q == align($past(pc_q) + 21'h00_0002))
        else $error("sequential step not two");
    a_sp_saturate: assert property (@(posedge sys_clk) disable iff (!resetn)
        (is_push && sp_q == 5'h1F && !ovr_reset_q) |=> sp_q == 5'h1F)
        else $error("pointer moved past 31");
    a_ovr_reset_sp: assert property (@(posedge sys_clk) disable iff (!resetn)
        (overflow_ev && ovr_reset_q) |=> sp_q == 5'h00 && full_q && stack_reset_req)
        else $error("overflow reset wrong");
    a_underflow_pc: assert property (@(posedge sys_clk) disable iff (!resetn || !por_n)
        (cmd == pc_stack_pkg::CMD_RETURN && sp_q == 5'h00) |=> pc_q == 21'h00_0000 && under_q)
        else $error("underflow handling wrong");
    a_call_return: assert property (@(posedge sys_clk) disable iff (!resetn)
        (cmd == pc_stack_pkg::CMD_CALL && sp_q < 5'h1E)
        ##1 (cmd == pc_stack_pkg::CMD_NONE && !sw_we) ##1 (cmd == pc_stack_pkg::CMD_RETURN)
        |=> pc_q == align($past(pc_q, 3) + 21'h00_0002))
        else $error("return address wrong");
    a_pcl_write: assert property (@(posedge sys_clk) disable iff (!resetn)
        (wr_pcl && cmd == pc_stack_pkg::CMD_NONE)
        |=> pc_q[20:8] == {$past(upper_latch_q), $past(high_latch_q)})
        else $error("latch transfer missing");
    a_pcl_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_pcl |=> high_latch_q == $past(pc_q[15:8]) && upper_latch_q == $past(pc_q[20:16]))
        else $error("latch copy missing");
    a_int_vector: assert property (@(posedge sys_clk) disable iff (!resetn)
        (cmd == pc_stack_pkg::CMD_INT_HIGH && !stack_rst) |=> pc_q == 21'h00_0008)
        else $error("high vector wrong");
    a_shadow_cap: assert property (@(posedge sys_clk) disable iff (!resetn)
        is_int |=> shadow_work_q == $past(working_register_in))
        else $error("shadow not captured");
endmodule : program_counter_return_stack

// ---- dv/decoder_model.sv ----
`timescale 1ns/100ps
module decoder_model (
    // Clock
    input wire logic sys_clk,
    // Program memory
    input wire logic [20:0] fetch_addr,
    output logic [15:0] mem_rdata,
    // Decoder outputs
    output pc_stack_pkg::cmd_t cmd,
    output logic [20:0] target,
    output logic fast,
    output logic [7:0] status_in,
    output logic [7:0] working_register_in,
    output logic [7:0] bank_select_register_in
);
    // Odd low bit keeps every implemented word non-zero
    assign mem_rdata = {fetch_addr[15:1], 1'b1};
    initial begin
        cmd = pc_stack_pkg::CMD_NONE;
        target = 21'h00_0000;
        fast = 1'b0;
        {status_in, working_register_in, bank_select_register_in} = 24'h00_0000;
    end
    task automatic issue(input pc_stack_pkg::cmd_t c, input logic [20:0] t, input logic f,
                         input logic [23:0] sh);
        @(posedge sys_clk);
        cmd <= c;
        target <= t;
        fast <= f;
        {status_in, working_register_in, bank_select_register_in} <= sh;
        @(posedge sys_clk);
        // Idle values differ from the last ones so a late capture shows
        cmd <= pc_stack_pkg::CMD_NONE;
        target <= ~t;
        fast <= 1'b0;
        {status_in, working_register_in, bank_select_register_in} <= ~sh;
        @(negedge sys_clk);
    endtask : issue
endmodule : decoder_model

// ---- dv/program_counter_return_stack_tb.sv ----
`timescale 1ns/100ps
module program_counter_return_stack_tb;
    logic sys_clk, resetn, por_n, fast, restore_valid, stack_reset_req;
    pc_stack_pkg::cmd_t cmd;
    logic [20:0] target, fetch_addr;
    logic [7:0] status_in, working_register_in, bank_select_register_in;
    logic [7:0] status_out, working_register_out, bank_select_register_out;
    logic [15:0] mem_rdata, fetch_data;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd_q;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, resp_q;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    int bad_count, n_tests, rst_cnt, r0, i;

    program_counter_return_stack #(.BIG_MEMORY(1'b0)) i_program_counter_return_stack (
        .sys_clk, .resetn, .por_n, .cmd, .target, .fast, .status_in, .working_register_in,
        .bank_select_register_in, .fetch_addr, .mem_rdata, .fetch_data, .restore_valid,
        .status_out, .working_register_out, .bank_select_register_out, .stack_reset_req,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready);
    decoder_model i_decoder_model (.sys_clk, .fetch_addr, .mem_rdata, .cmd, .target, .fast,
        .status_in, .working_register_in, .bank_select_register_in);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (stack_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
    end

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic hang(input string name);
        bad_count++;
        $display("Error %s expected answer seen timeout", name);
        finish_test();
    endtask : hang
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1 && n < 100);
        s_bready <= 1'b0;
        resp_q = s_bresp;
        if (n >= 100) hang("write");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        int n = 0;
        @(posedge sys_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1 && n < 100);
        s_rready <= 1'b0;
        rd_q = s_rdata;
        resp_q = s_rresp;
        if (n >= 100) hang("read");
    endtask : axi_rd
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(name, exp, rd_q);
    endtask : rd_chk
    task automatic st_chk(input logic [7:0] exp);
        rd_chk("stack_status", pc_stack_pkg::ADDR_STACK_STATUS, {24'h00_0000, exp});
    endtask : st_chk
    task automatic top_chk(input logic [20:0] exp);
        logic [23:0] v;
        axi_rd(pc_stack_pkg::ADDR_TOP_LOW);
        v[7:0] = rd_q[7:0];
        axi_rd(pc_stack_pkg::ADDR_TOP_HIGH);
        v[15:8] = rd_q[7:0];
        axi_rd(pc_stack_pkg::ADDR_TOP_UPPER);
        v[23:16] = rd_q[7:0];
        chk("top_entry", {11'h000, exp}, {8'h00, v});
    endtask : top_chk
    task automatic pc_chk(input logic [20:0] exp);
        chk("fetch_addr", {11'h000, exp}, {11'h000, fetch_addr});
    endtask : pc_chk
    task automatic op(input pc_stack_pkg::cmd_t c, input logic [20:0] t);
        i_decoder_model.issue(c, t, 1'b0, 24'h00_0000);
    endtask : op
    task automatic shadow_chk(input logic [23:0] exp);
        int n = 0;
        while (restore_valid !== 1'b1 && n < 4) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 4) hang("restore_valid");
        chk("shadow", {8'h00, exp},
            {8'h00, status_out, working_register_out, bank_select_register_out});
    endtask : shadow_chk
    task automatic fetch_chk(input logic [20:0] a, input logic [15:0] exp);
        op(pc_stack_pkg::CMD_JUMP, a);
        repeat (2) @(negedge sys_clk);
        pc_chk(a);
        chk("fetch_data", {16'h0000, exp}, {16'h0000, fetch_data});
    endtask : fetch_chk
    task automatic calls31(input logic [20:0] base);
        for (i = 0; i < 31; i++) op(pc_stack_pkg::CMD_CALL, base + 21'(i * 4));
        repeat (2) @(negedge sys_clk);
    endtask : calls31

    initial begin
        {bad_count, n_tests, rst_cnt} = '0;
        {resetn, por_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hF;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        @(negedge sys_clk);
        pc_chk(pc_stack_pkg::RESET_VECTOR);
        st_chk(8'h00);
        rd_chk("config", pc_stack_pkg::ADDR_CONFIG, 32'h0000_0001);
        $display("test reset done");
        op(pc_stack_pkg::CMD_SEQ, 21'h00_0000);
        pc_chk(21'h00_0002);
        op(pc_stack_pkg::CMD_JUMP, 21'h12_3457);
        pc_chk(21'h12_3456);
        axi_wr(pc_stack_pkg::ADDR_HIGH_LATCH, 32'h0000_0012);
        axi_wr(pc_stack_pkg::ADDR_UPPER_LATCH, 32'h0000_0005);
        axi_wr(pc_stack_pkg::ADDR_COUNTER_LOW, 32'h0000_0035);
        pc_chk(21'h05_1234);
        op(pc_stack_pkg::CMD_JUMP, 21'h0A_BC00);
        rd_chk("counter_low", pc_stack_pkg::ADDR_COUNTER_LOW, 32'h0000_0000);
        rd_chk("high_latch", pc_stack_pkg::ADDR_HIGH_LATCH, 32'h0000_00BC);
        rd_chk("upper_latch", pc_stack_pkg::ADDR_UPPER_LATCH, 32'h0000_000A);
        $display("test counter done");
        op(pc_stack_pkg::CMD_JUMP, 21'h00_0100);
        op(pc_stack_pkg::CMD_CALL, 21'h00_0200);
        pc_chk(21'h00_0200);
        st_chk(8'h01);
        top_chk(21'h00_0102);
        rd_chk("high_latch", pc_stack_pkg::ADDR_HIGH_LATCH, 32'h0000_00BC);
        axi_wr(pc_stack_pkg::ADDR_TOP_LOW, 32'h0000_0050);
        axi_wr(pc_stack_pkg::ADDR_TOP_HIGH, 32'h0000_0033);
        axi_wr(pc_stack_pkg::ADDR_TOP_UPPER, 32'h0000_0001);
        op(pc_stack_pkg::CMD_RETURN, 21'h00_0000);
        pc_chk(21'h01_3350);
        st_chk(8'h00);
        op(pc_stack_pkg::CMD_SW_PUSH, 21'h00_0000);
        top_chk(21'h01_3350);
        op(pc_stack_pkg::CMD_SW_PUSH, 21'h00_0000);
        op(pc_stack_pkg::CMD_SW_POP, 21'h00_0000);
        st_chk(8'h01);
        top_chk(21'h01_3350);
        axi_wr(pc_stack_pkg::ADDR_STACK_STATUS, 32'h0000_0000);
        $display("test stack done");
        i_decoder_model.issue(pc_stack_pkg::CMD_INT_LOW, 21'h00_0000, 1'b0, 24'h11_2233);
        pc_chk(pc_stack_pkg::LOW_VECTOR);
        i_decoder_model.issue(pc_stack_pkg::CMD_INT_HIGH, 21'h00_0000, 1'b0, 24'h44_5566);
        pc_chk(pc_stack_pkg::HIGH_VECTOR);
        st_chk(8'h02);
        i_decoder_model.issue(pc_stack_pkg::CMD_RETURN, 21'h00_0000, 1'b1, 24'h00_0000);
        shadow_chk(24'h44_5566);
        i_decoder_model.issue(pc_stack_pkg::CMD_CALL, 21'h00_0300, 1'b1, 24'h77_8899);
        i_decoder_model.issue(pc_stack_pkg::CMD_RETURN, 21'h00_0000, 1'b1, 24'h00_0000);
        shadow_chk(24'h77_8899);
        $display("test shadow done");
        axi_wr(pc_stack_pkg::ADDR_STACK_STATUS, 32'h0000_0000);
        r0 = rst_cnt;
        op(pc_stack_pkg::CMD_RETURN, 21'h00_0000);
        repeat (2) @(negedge sys_clk);
        chk("reset_requests", 32'd1, 32'(rst_cnt - r0));
        pc_chk(pc_stack_pkg::RESET_VECTOR);
        st_chk(8'h40);
        op(pc_stack_pkg::CMD_CALL, 21'h00_0040);
        @(posedge sys_clk);
        resetn <= 1'b0;
        @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        st_chk(8'h40);
        axi_wr(pc_stack_pkg::ADDR_STACK_STATUS, 32'h0000_0000);
        st_chk(8'h00);
        axi_wr(pc_stack_pkg::ADDR_CONFIG, 32'h0000_0000);
        r0 = rst_cnt;
        op(pc_stack_pkg::CMD_RETURN, 21'h00_0000);
        repeat (2) @(negedge sys_clk);
        chk("reset_requests", 32'd0, 32'(rst_cnt - r0));
        st_chk(8'h40);
        $display("test underflow done");
        axi_wr(pc_stack_pkg::ADDR_STACK_STATUS, 32'h0000_0000);
        calls31(21'h00_0400);
        st_chk(8'h9F);
        top_chk(21'h00_0476);
        op(pc_stack_pkg::CMD_CALL, 21'h00_0500);
        st_chk(8'h9F);
        top_chk(21'h00_0476);
        op(pc_stack_pkg::CMD_RETURN, 21'h00_0000);
        pc_chk(21'h00_0476);
        axi_wr(pc_stack_pkg::ADDR_STACK_STATUS, 32'h0000_0000);
        axi_wr(pc_stack_pkg::ADDR_CONFIG, 32'h0000_0001);
        r0 = rst_cnt;
        calls31(21'h00_0800);
        chk("reset_requests", 32'd1, 32'(rst_cnt - r0));
        pc_chk(pc_stack_pkg::RESET_VECTOR);
        st_chk(8'h80);
        axi_wr(pc_stack_pkg::ADDR_STACK_STATUS, 32'h0000_009F);
        top_chk(21'h00_0876);
        $display("test overflow done");
        fetch_chk(21'h00_1FFE, 16'h1FFF);
        fetch_chk(pc_stack_pkg::MEM_8K, 16'h0000);
        fetch_chk(21'h1F_FFFE, 16'h0000);
        axi_rd(8'h24);
        chk("read_resp", {30'h0, pc_stack_pkg::RESP_SLVERR}, {30'h0, resp_q});
        chk("read_data", 32'h0000_0000, rd_q);
        axi_wr(8'h24, 32'h0000_0001);
        chk("write_resp", {30'h0, pc_stack_pkg::RESP_SLVERR}, {30'h0, resp_q});
        $display("test memory done");
        finish_test();
    end
endmodule : program_counter_return_stack_tb
